// *** pkg/fsr_pkg.sv ***
// Purpose: constants and types for the status-two / config-one register block
// Assumes: single-bit spi (mode 0), msb first, 8-bit command codes
// Notes: bit positions and command codes shared by logic and bench
package fsr_pkg;
  localparam logic [7:0] CMD_READ_STATUS_TWO = 8'h07;
  localparam logic [7:0] CMD_READ_ANY_REG = 8'h65;
  localparam logic [7:0] CMD_WRITE_REGISTERS = 8'h01;
  localparam logic [7:0] CMD_WRITE_ANY_REG = 8'h71;
  localparam logic [7:0] CMD_ERASE_STATUS = 8'hD0;
  // register addresses used by the any-register commands (24-bit address)
  localparam logic [23:0] ADDR_STATUS_TWO = 24'h800001;
  localparam logic [23:0] ADDR_CONFIG_ONE_NV = 24'h000002;
  localparam int BIT_PROG_PAUSED = 0;
  localparam int BIT_ERASE_PAUSED = 1;
  localparam int BIT_WIPE_RESULT = 2;
  localparam int BIT_LOCK_DEFAULT = 0;
  localparam int BIT_FOUR_WIDE = 1;
  localparam int BIT_PARAM_TOP = 2;
  localparam int BIT_PROT_VOLATILE = 3;
  localparam int BIT_PROT_ORIGIN = 5;
  localparam logic [7:0] CONFIG_ONE_RESET = 8'h00;
  localparam logic [2:0] PROT_BITS_RESET = 3'h0;
  localparam logic [2:0] PROT_BITS_ALL = 3'h7;
  localparam logic [7:0] STATUS_TWO_MASK = 8'h07;
  localparam logic [7:0] CONFIG_ONE_MASK = 8'h2F;
  typedef struct packed {
    logic [7:0] data;
    logic is_cmd;
  } fsr_byte_t;
endpackage

// *** logic/fsr_regs.sv ***
// Purpose: status register two and non-volatile config register one
// Assumes: spi mode 0 on i_sck; one command per chip-select frame
// Notes: all spi decoding on i_sck domain; core state on i_clk
//   nonvolatile cells are modelled as flops that reset clears
//   the spi side reads core registers directly; they only move between
//   frames or on hardware events, so a torn read is at worst one stale bit
//   the core reset also clears the spi side, which must then stand idle
// How it works
// - status two returned by dedicated read or read-any-register command.
// - status two bits come only from hardware, host cannot write them.
// - bit 2 reports whether queried sector finished its last erase.
// - during suspend the wipe result bit is not guaranteed valid.
// - bit 1 follows erase suspend state; writes ignored.
// - bit 0 follows program suspend state; writes ignored.
// - config one written by write-registers second byte or write-any-register.
// - protect origin 0 anchors protection at top, 1 at address zero.
// - one-time bits set to 1 stay 1; no program error raised.
// - one-time bits and non-volatile protection bits reset to zero.
// - select 0: nv protection bits govern; write-registers updates them.
// - setting volatile-select programs nonvolatile protection bits to 111.
// - select 1: write-registers updates only volatile protection bits.
// - param-top 1 puts small parameter sectors at top, else bottom.
// - with uniform sectors param-top is ignored for the map.
// - protect origin and param location are set independently.
// - four-wide default seeds quad bit; both write commands change it.
// - nonvolatile quad command mode set also programs four-wide default.
// - while volatile quad command mode set, clearing four-wide is rejected.
// - lock default seeds lock bit; read-only to host.
`timescale 1ns/1ps
module fsr_regs (
  input wire logic i_clk, // core clock
  input wire logic i_rst, // reset, high; synchronous on i_clk, asynchronous on the spi side
  input wire logic i_sck, // spi serial clock
  input wire logic i_cs_n, // spi chip select, low active
  input wire logic i_mosi, // spi data in
  output logic o_miso, // spi data out
  output logic o_miso_oe, // high while driving data out
  input wire logic i_erase_paused, // core in erase suspend
  input wire logic i_prog_paused, // core in program suspend
  input wire logic i_wipe_done, // result for queried sector
  input wire logic i_wipe_valid, // pulse: erase-status query answered
  input wire logic i_uniform_sectors, // array is uniform sector map
  input wire logic i_quad_cmd_mode_v, // volatile quad command mode
  input wire logic i_quad_cmd_mode_nv_set, // pulse: nv quad cmd mode set
  input wire logic i_write_enabled, // write enable latch
  input wire logic i_lock_default, // factory lock default value
  output logic [7:0] o_status_two, // status two value
  output logic [7:0] o_config_one, // config one value
  output logic [2:0] o_prot_bits, // protection bits in force
  output logic o_prot_from_zero, // protection anchored at address zero
  output logic o_param_at_top, // parameter sectors at top
  output logic o_quad_default, // power-up quad bit value
  output logic o_lock_default, // power-up lock bit value
  output logic o_query_pulse // pulse: erase-status query seen
);
  // -------- spi domain --------
  logic [5:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] cmd_r;
  logic [23:0] addr_r;
  logic [7:0] byte1_r;
  logic [7:0] tx_r;
  logic miso_r;
  logic drive_r;
  logic wr_tgl_r;
  logic q_tgl_r;
  fsr_pkg::fsr_byte_t wr_hold_r;
  logic [7:0] wr_hold2_r;
  logic [1:0] wr_kind_r;
  logic [7:0] rd_sel;
  logic [7:0] rx_byte;

  assign rx_byte = {shift_r[6:0], i_mosi};

  // frame position decodes, named once so the sck processes agree on them
  logic at_query_cmd;
  logic at_wrr_end;
  logic at_wany_end;
  logic at_rd2_start;
  logic at_rdany_start;
  assign at_query_cmd = (bit_cnt_r == 6'h07) &&
                        (rx_byte == fsr_pkg::CMD_ERASE_STATUS);
  assign at_wrr_end = (bit_cnt_r == 6'h17) &&
                      (cmd_r == fsr_pkg::CMD_WRITE_REGISTERS);
  assign at_wany_end = (bit_cnt_r == 6'h27) &&
                       (cmd_r == fsr_pkg::CMD_WRITE_ANY_REG);
  assign at_rd2_start = (bit_cnt_r == 6'h08) &&
                        (cmd_r == fsr_pkg::CMD_READ_STATUS_TWO);
  assign at_rdany_start = (bit_cnt_r == 6'h20) &&
                          (cmd_r == fsr_pkg::CMD_READ_ANY_REG);

  // snapshots of core values read on sck; they are quasi-static registers
  logic [7:0] stat_snap;
  logic [7:0] cfg_snap;
  assign stat_snap = o_status_two;
  assign cfg_snap = o_config_one;

  // the read source is chosen on the falling edge after the last address
  // bit, when the address register already holds all three bytes
  always_comb begin
    rd_sel = 8'h00;
    case (cmd_r)
      fsr_pkg::CMD_READ_STATUS_TWO: begin
        rd_sel = stat_snap;
      end
      fsr_pkg::CMD_READ_ANY_REG: begin
        if (addr_r == fsr_pkg::ADDR_STATUS_TWO) begin
          rd_sel = stat_snap;
        end else if (addr_r == fsr_pkg::ADDR_CONFIG_ONE_NV) begin
          rd_sel = cfg_snap;
        end else begin
          rd_sel = 8'h00;
        end
      end
      default: begin
        rd_sel = 8'h00;
      end
    endcase
  end

  // the bit counter saturates so a long frame cannot wrap into a new
  // command phase and fire a second write
  always_ff @(posedge i_sck or posedge i_cs_n or posedge i_rst) begin
    if (i_cs_n || i_rst) begin
      bit_cnt_r <= 6'h00;
      shift_r <= 8'h00;
      cmd_r <= 8'h00;
      addr_r <= 24'h000000;
      byte1_r <= 8'h00;
    end else begin
      shift_r <= rx_byte;
      if (bit_cnt_r != 6'h3F) begin
        bit_cnt_r <= bit_cnt_r + 6'h01;
      end
      if (bit_cnt_r == 6'h07) begin
        cmd_r <= rx_byte;
      end
      if (bit_cnt_r[2:0] == 3'h7 && bit_cnt_r > 6'h07 &&
          bit_cnt_r < 6'h20) begin
        addr_r <= {addr_r[15:0], rx_byte};
      end
      if (bit_cnt_r == 6'h0F) begin
        byte1_r <= rx_byte;
      end
    end
  end

  // write and query events leave the spi domain as toggles; the core reset
  // clears them too, so both sides of the crossing start at one level
  always_ff @(posedge i_sck or posedge i_rst) begin
    if (i_rst) begin
      q_tgl_r <= 1'b0;
    end else if (!i_cs_n && at_query_cmd) begin
      q_tgl_r <= ~q_tgl_r;
    end
  end

  // the payload stays put until the next write frame ends, far longer
  // than the few core cycles that the toggle needs to cross
  always_ff @(posedge i_sck or posedge i_rst) begin
    if (i_rst) begin
      wr_hold_r <= '0;
      wr_hold2_r <= 8'h00;
      wr_kind_r <= 2'h0;
      wr_tgl_r <= 1'b0;
    end else if (!i_cs_n && at_wrr_end) begin
      // sixteen input cycles: status one byte then config byte
      wr_hold_r.data <= rx_byte;
      wr_hold_r.is_cmd <= 1'b1;
      wr_hold2_r <= byte1_r;
      wr_kind_r <= 2'h1;
      wr_tgl_r <= ~wr_tgl_r;
    end else if (!i_cs_n && at_wany_end) begin
      // only the config address is writable; other targets are dropped
      wr_hold_r.data <= rx_byte;
      wr_hold_r.is_cmd <= 1'b0;
      wr_hold2_r <= 8'h00;
      wr_kind_r <= (addr_r == fsr_pkg::ADDR_CONFIG_ONE_NV) ? 2'h2 : 2'h0;
      wr_tgl_r <= ~wr_tgl_r;
    end
  end

  // the output enable rises with the first data bit and holds to frame end
  always_ff @(negedge i_sck or posedge i_cs_n or posedge i_rst) begin
    if (i_cs_n || i_rst) begin
      drive_r <= 1'b0;
    end else if (at_rd2_start || at_rdany_start) begin
      drive_r <= 1'b1;
    end
  end

  // miso launches on the falling edge so the host samples it on the rise;
  // zeros follow once the byte is spent
  always_ff @(negedge i_sck or posedge i_cs_n or posedge i_rst) begin
    if (i_cs_n || i_rst) begin
      tx_r <= 8'h00;
      miso_r <= 1'b0;
    end else if (at_rd2_start || at_rdany_start) begin
      tx_r <= {rd_sel[6:0], 1'b0};
      miso_r <= rd_sel[7];
    end else begin
      tx_r <= {tx_r[6:0], 1'b0};
      miso_r <= tx_r[7];
    end
  end

  always_comb begin
    o_miso = miso_r;
    o_miso_oe = drive_r;
  end

  // -------- core domain --------
  // each event toggle passes three flip-flops; an event counts once the
  // second and third stages agree on a level not yet taken
  localparam int NUM_EVT = 2;
  logic [NUM_EVT-1:0] evt_tgl;
  logic [NUM_EVT-1:0] evt_pulse;
  logic wr_evt;
  logic q_evt;
  assign evt_tgl = {q_tgl_r, wr_tgl_r};
  assign wr_evt = evt_pulse[0];
  assign q_evt = evt_pulse[1];

  for (genvar g = 0; g < NUM_EVT; g++) begin : g_evt
    logic [2:0] sync_r;
    logic seen_r;
    // only the second stage reads the first, so a metastable first stage
    // never reaches the event decode
    assign evt_pulse[g] = (sync_r[2] == sync_r[1]) &&
                          (sync_r[1] != seen_r);
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        sync_r <= 3'h0;
        seen_r <= 1'b0;
      end else begin
        sync_r <= {sync_r[1:0], evt_tgl[g]};
        if (evt_pulse[g]) begin
          seen_r <= sync_r[1];
        end
      end
    end
  end

  // payload is stable for many core cycles after the toggle settles
  logic [7:0] wr_data;
  logic [7:0] wr_stat1;
  logic [1:0] wr_kind;
  assign wr_data = wr_hold_r.data;
  assign wr_stat1 = wr_hold2_r;
  assign wr_kind = wr_kind_r;

  logic wipe_r;
  logic prot_vsel_r;
  logic origin_r;
  logic param_r;
  logic quad_r;
  logic [2:0] nv_prot_r;
  logic [2:0] v_prot_r;
  logic cfg_wr;
  // a write with the write latch clear is dropped whole; nothing is
  // half-applied from a refused frame
  assign cfg_wr = wr_evt && i_write_enabled && wr_kind != 2'h0;

  // the wipe result holds until the next query answer replaces it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wipe_r <= 1'b0;
    end else if (i_wipe_valid) begin
      wipe_r <= i_wipe_done;
    end
  end

  // one-time bits only ever move 0 to 1
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      origin_r <= fsr_pkg::CONFIG_ONE_RESET[fsr_pkg::BIT_PROT_ORIGIN];
      param_r <= fsr_pkg::CONFIG_ONE_RESET[fsr_pkg::BIT_PARAM_TOP];
      prot_vsel_r <= fsr_pkg::CONFIG_ONE_RESET[fsr_pkg::BIT_PROT_VOLATILE];
    end else if (cfg_wr) begin
      origin_r <= origin_r | wr_data[fsr_pkg::BIT_PROT_ORIGIN];
      param_r <= param_r | wr_data[fsr_pkg::BIT_PARAM_TOP];
      prot_vsel_r <= prot_vsel_r | wr_data[fsr_pkg::BIT_PROT_VOLATILE];
    end
  end

  // a set of the nonvolatile quad mode wins over a host write in the same
  // cycle; a clear is refused while the volatile quad mode is on
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      quad_r <= fsr_pkg::CONFIG_ONE_RESET[fsr_pkg::BIT_FOUR_WIDE];
    end else if (i_quad_cmd_mode_nv_set) begin
      quad_r <= 1'b1;
    end else if (cfg_wr) begin
      if (wr_data[fsr_pkg::BIT_FOUR_WIDE] || !i_quad_cmd_mode_v) begin
        quad_r <= wr_data[fsr_pkg::BIT_FOUR_WIDE];
      end
    end
  end

  // protection bits; nonvolatile copy survives reset in a real part
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      nv_prot_r <= fsr_pkg::PROT_BITS_RESET;
      v_prot_r <= fsr_pkg::PROT_BITS_RESET;
    end else if (cfg_wr && !prot_vsel_r &&
                 wr_data[fsr_pkg::BIT_PROT_VOLATILE]) begin
      nv_prot_r <= fsr_pkg::PROT_BITS_ALL;
      v_prot_r <= fsr_pkg::PROT_BITS_ALL;
    end else if (wr_evt && i_write_enabled && wr_hold_r.is_cmd) begin
      // only the write-registers command carries protection bits
      if (!prot_vsel_r) begin
        nv_prot_r <= wr_stat1[4:2];
        v_prot_r <= wr_stat1[4:2];
      end else begin
        v_prot_r <= wr_stat1[4:2];
      end
    end
  end

  // both registers are rebuilt every cycle from core state, so nothing
  // the host sends reaches a read-only or reserved bit
  logic wipe_shown;
  logic [7:0] status_two_nxt;
  logic [7:0] config_one_nxt;
  // a suspended device shows no wipe result rather than a stale one
  assign wipe_shown = wipe_r & ~(i_erase_paused | i_prog_paused);
  assign status_two_nxt = {5'h00, wipe_shown, i_erase_paused,
                           i_prog_paused} & fsr_pkg::STATUS_TWO_MASK;
  assign config_one_nxt = {2'h0, origin_r, 1'b0, prot_vsel_r, param_r,
                           quad_r, i_lock_default} &
                          fsr_pkg::CONFIG_ONE_MASK;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_status_two <= 8'h00;
      o_config_one <= fsr_pkg::CONFIG_ONE_RESET;
    end else begin
      o_status_two <= status_two_nxt;
      o_config_one <= config_one_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_query_pulse <= 1'b0;
    end else begin
      o_query_pulse <= q_evt;
    end
  end

  // these follow the working copies directly, one cycle ahead of the
  // registered config byte

  always_comb begin
    o_prot_bits = prot_vsel_r ? v_prot_r : nv_prot_r;
    o_prot_from_zero = origin_r;
    o_param_at_top = param_r & ~i_uniform_sectors;
    o_quad_default = quad_r;
    o_lock_default = i_lock_default;
  end
endmodule

// *** bench/fsr_spi_host.sv ***
// Purpose: spi host model that frames commands into the register block
// Assumes: mode 0, msb first, one command per chip-select frame
// Notes: sck stands low outside frames; mosi flips 6 ns before chip select is released
`timescale 1ns/1ps
module fsr_spi_host (
  output logic o_sck, // serial clock
  output logic o_cs_n, // chip select, low active
  output logic o_mosi, // host data out
  input wire logic i_miso // device data out
);
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // 12 ns sck; miso is taken at each rising edge
  task automatic xfer(input int n, input logic [47:0] tx,
                      output logic [47:0] rx);
    rx = '0;
    o_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_mosi = tx[i];
      #3 o_sck = 1'b1;
      rx = {rx[46:0], i_miso};
      #6 o_sck = 1'b0;
      #3;
    end
    o_mosi = ~o_mosi;
    #6 o_cs_n = 1'b1;
    #12;
  endtask
endmodule

// *** bench/fsr_regs_assertions.sv ***
// Purpose: port-level checks of the core side of the register block
// Assumes: one clock domain watched; spi traffic judged by the bench
// Notes: status two lags its inputs by one clock
`timescale 1ns/1ps
module fsr_regs_chk (
  input wire logic i_clk, // core clock
  input wire logic i_rst, // sync reset
  input wire logic i_erase_paused, // erase suspend
  input wire logic i_prog_paused, // program suspend
  input wire logic i_uniform_sectors, // uniform map
  input wire logic i_quad_cmd_mode_v, // volatile quad mode
  input wire logic i_quad_cmd_mode_nv_set, // nv quad mode pulse
  input wire logic i_lock_default, // lock default in
  input wire logic [7:0] o_status_two, // status two
  input wire logic [7:0] o_config_one, // config one
  input wire logic [2:0] o_prot_bits, // protection in force
  input wire logic o_prot_from_zero, // origin at zero
  input wire logic o_param_at_top, // params on top
  input wire logic o_lock_default // lock default out
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_vol_rise;
    !o_config_one[3] ##1 o_config_one[3];
  endsequence
  a_status_reserved: assert property (o_status_two[7:3] == 5'h00)
    else $error("status two reserved bit set");
  a_erase_flag_lag: assert property (!$past(i_rst) |->
    o_status_two[1] == $past(i_erase_paused)) else $error("erase flag");
  a_prog_flag_lag: assert property (!$past(i_rst) |->
    o_status_two[0] == $past(i_prog_paused)) else $error("program flag");
  a_wipe_paused_low: assert property (!$past(i_rst) &&
    $past(i_erase_paused | i_prog_paused) |-> !o_status_two[2])
    else $error("wipe result while paused");
  a_cfg_reserved: assert property (o_config_one[7:6] == 2'h0 &&
    !o_config_one[4]) else $error("config reserved bit set");
  a_otp_sticky: assert property (!$past(i_rst) |->
    ($past(o_config_one) & 8'h2C & ~o_config_one) == 8'h00)
    else $error("one-time bit cleared");
  a_prot_all_ones: assert property (s_vol_rise |->
    o_prot_bits == 3'h7) else $error("protection not all ones");
  a_origin_follows: assert property (!$past(i_rst) |->
    $past(o_prot_from_zero) == o_config_one[5]) else $error("origin output");
  a_param_map: assert property (!$past(i_rst) |->
    $past(o_param_at_top) == (o_config_one[2] && !$past(i_uniform_sectors)))
    else $error("param map");
  a_lock_passes: assert property (o_lock_default == i_lock_default)
    else $error("lock default output");
  a_four_wide_default_sets: assert property (i_quad_cmd_mode_nv_set |->
    ##[1:4] o_config_one[1]) else $error("nv quad mode missed");
  a_quad_kept: assert property (!$past(i_rst) &&
    $past(i_quad_cmd_mode_v) && $past(o_config_one[1]) |-> o_config_one[1])
    else $error("quad cleared");
  a_reset_clear: assert property ($past(i_rst) |->
    o_config_one[7:1] == 7'h00 && o_prot_bits == 3'h0) else $error("reset");
endmodule
bind fsr_regs fsr_regs_chk i_fsr_regs_chk (.i_clk, .i_rst, .i_erase_paused,
  .i_prog_paused, .i_uniform_sectors, .i_quad_cmd_mode_v,
  .i_quad_cmd_mode_nv_set, .i_lock_default, .o_status_two, .o_config_one,
  .o_prot_bits, .o_prot_from_zero, .o_param_at_top, .o_lock_default);

// *** bench/fsr_regs_bench.sv ***
// Purpose: self-checking bench for the status-two / config-one block
// Assumes: host model frames every command; core inputs move on negedge
// Notes: nonvolatile state is lost on reset in this model
`timescale 1ns/1ps
module fsr_regs_bench;
  logic i_clk = 1'b0, i_rst = 1'b1, sck, cs_n, mosi, miso, oe, pz, pt;
  logic ep = 1'b0, pp = 1'b0, wd = 1'b0, wv = 1'b0, uni = 1'b0, qp;
  logic qv = 1'b0, qs = 1'b0, we = 1'b0, lk = 1'b1, qd, ld;
  logic [7:0] st2, cfg;
  logic [2:0] prot;
  logic [47:0] rx;
  int miscompares = 0, num_checks = 0, cyc = 0;
  fsr_spi_host i_fsr_spi_host (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi),
    .i_miso(oe ? miso : ~miso));
  fsr_regs i_fsr_regs (.i_clk, .i_rst, .i_sck(sck), .i_cs_n(cs_n),
    .i_mosi(mosi), .o_miso(miso), .o_miso_oe(oe), .i_erase_paused(ep),
    .i_prog_paused(pp), .i_wipe_done(wd), .i_wipe_valid(wv),
    .i_uniform_sectors(uni), .i_quad_cmd_mode_v(qv),
    .i_quad_cmd_mode_nv_set(qs), .i_write_enabled(we), .i_lock_default(lk),
    .o_status_two(st2), .o_config_one(cfg), .o_prot_bits(prot),
    .o_prot_from_zero(pz), .o_param_at_top(pt), .o_quad_default(qd),
    .o_lock_default(ld), .o_query_pulse(qp));
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  task automatic close_out;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xf(input int n, input logic [47:0] tx);
    i_fsr_spi_host.xfer(n, tx, rx);
    repeat (8) @(negedge i_clk);
  endtask
  task automatic rcfg(input logic [7:0] e);
    xf(40, {8'h00, fsr_pkg::CMD_READ_ANY_REG, fsr_pkg::ADDR_CONFIG_ONE_NV,
            8'h00});
    chk("config read", rx[7:0], e);
    chk("config port", cfg, e);
  endtask
  task automatic wany(input logic [23:0] a, input logic [7:0] d);
    xf(40, {8'h00, fsr_pkg::CMD_WRITE_ANY_REG, a, d});
  endtask
  task automatic write_registers_cmd(input logic [7:0] s1, c1);
    xf(24, {24'h000000, fsr_pkg::CMD_WRITE_REGISTERS, s1, c1});
  endtask
  task automatic rd2;
    xf(16, {32'h0, fsr_pkg::CMD_READ_STATUS_TWO, 8'h00});
  endtask
  task automatic query(input logic done);
    int n;
    i_fsr_spi_host.xfer(8, {40'h0, fsr_pkg::CMD_ERASE_STATUS}, rx);
    n = 0;
    repeat (10) @(negedge i_clk) n += int'(qp === 1'b1);
    chk("query pulse", n[7:0], 8'h01);
    @(negedge i_clk) {wd, wv} = {done, 1'b1};
    @(negedge i_clk) wv = 1'b0;
    repeat (3) @(negedge i_clk);
  endtask
  task automatic t_reset;
    rcfg(8'h01);
    chk("prot reset", {5'h00, prot}, 8'h00);
    chk("lock default", {7'h00, ld}, 8'h01);
    chk("miso idle", {7'h00, oe}, 8'h00);
    xf(40, {8'h00, fsr_pkg::CMD_READ_ANY_REG, 24'h000003, 8'h00});
    chk("unmapped", rx[7:0], 8'h00);
  endtask
  task automatic t_status;
    ep = 1'b1;
    we = 1'b1;
    wany(fsr_pkg::ADDR_STATUS_TWO, 8'hFF);
    rd2();
    chk("erase paused", rx[7:0], 8'h02);
    {ep, pp} = 2'b01;
    query(1'b1);
    xf(40, {8'h00, fsr_pkg::CMD_READ_ANY_REG, fsr_pkg::ADDR_STATUS_TWO,
            8'h00});
    chk("prog paused", rx[7:0], 8'h01);
    pp = 1'b0;
    query(1'b1);
    rd2();
    chk("wipe done", rx[7:0], 8'h04);
    query(1'b0);
    rd2();
    chk("wipe not done", rx[7:0], 8'h00);
  endtask
  // origin and param bits are chosen before any array traffic
  task automatic t_config;
    we = 1'b0;
    wany(fsr_pkg::ADDR_CONFIG_ONE_NV, 8'h20);
    rcfg(8'h01);
    we = 1'b1;
    write_registers_cmd(8'h14, 8'h24);
    rcfg(8'h25);
    chk("prot nv", {5'h00, prot}, 8'h05);
    chk("origin zero", {7'h00, pz}, 8'h01);
    uni = 1'b1;
    wany(fsr_pkg::ADDR_CONFIG_ONE_NV, 8'hD0);
    chk("uniform map", {7'h00, pt}, 8'h00);
    rcfg(8'h25);
    uni = 1'b0;
    wany(fsr_pkg::ADDR_CONFIG_ONE_NV, 8'h08);
    chk("prot ones", {5'h00, prot}, 8'h07);
    write_registers_cmd(8'h08, 8'h00);
    chk("prot volatile", {5'h00, prot}, 8'h02);
    qv = 1'b1;
    wany(fsr_pkg::ADDR_CONFIG_ONE_NV, 8'h02);
    write_registers_cmd(8'h08, 8'h00);
    rcfg(8'h2F);
    qv = 1'b0;
    write_registers_cmd(8'h08, 8'h00);
    rcfg(8'h2D);
    qs = 1'b1;
    @(negedge i_clk) qs = 1'b0;
    repeat (6) @(negedge i_clk);
    rcfg(8'h2F);
    chk("quad default", {7'h00, qd}, 8'h01);
  endtask
  initial begin
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (2) @(negedge i_clk);
    t_reset();
    t_status();
    t_config();
    close_out();
  end
endmodule
